// ===== src/uart_status_pkg.sv
// constants and types shared by the serial port status flag logic
package uart_status_pkg;

  // bus geometry
  localparam int          ADDR_W = 32;
  localparam int          DATA_W = 32;

  // register byte addresses
  localparam logic [31:0] STATUS_ADDR   = 32'h5000_117C;
  localparam logic [31:0] DIVISOR_ADDR  = 32'h5000_11A0;
  localparam logic [31:0] CLK_MODE_ADDR = 32'h5000_11A4;

  // status register field positions
  localparam int          BUSY_BIT = 0;
  localparam int          TFNF_BIT = 1;
  localparam int          TFE_BIT  = 2;
  localparam int          RFNE_BIT = 3;
  localparam int          RFF_BIT  = 4;

  // fifo geometry
  localparam int          LEVEL_W    = 5;
  localparam logic [4:0]  FIFO_DEPTH = 5'h10;

  // reset values of the flags
  localparam logic        RFF_RESET  = 1'h0;
  localparam logic        RFNE_RESET = 1'h0;
  localparam logic        TFE_RESET  = 1'h1;
  localparam logic        TFNF_RESET = 1'h1;
  localparam logic        BUSY_RESET = 1'h0;

  // baud divisor and clock mode registers
  localparam int          DIV_W          = 16;
  localparam logic [15:0] DIV_RESET      = 16'h0001;
  localparam logic        CLK_MODE_RESET = 1'h0;

  // receive start-bit and frame timing, in 16x oversample ticks
  localparam int          CNT_W       = 8;
  localparam logic [7:0]  MID_TICKS   = 8'h08;
  localparam logic [7:0]  FRAME_TICKS = 8'h98;

  // emulated slow serial clock and busy synchroniser depth
  localparam logic [3:0]  SLOW_DIV         = 4'h4;
  localparam logic [2:0]  SYNC_SLOW_CYCLES = 3'h3;

  // activity inputs from the serial engine and fifos
  typedef struct packed {
    logic [4:0] tx_level;
    logic [4:0] rx_level;
    logic       tx_shifting;
    logic       rx_line;
  } engine_type;

  // flag set as seen by software
  typedef struct packed {
    logic rx_fifo_full_flag;
    logic rx_fifo_not_empty_flag;
    logic tx_fifo_empty_flag;
    logic tx_fifo_not_full_flag;
    logic busy_flag;
  } status_type;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START_CHECK,
    RX_FRAME
  } rx_state_type;

endpackage

// ===== src/uart_fifo_status_flags.sv
// status flags of the serial port with their register access port
//
// What this block does
// R1: bit 4 high while receive fifo full
// R2: bit 3 high while receive fifo nonempty
// R3: bit 2 high while transmit fifo empty
// R4: bit 1 high while transmit fifo has room
// R5: bit 0 high during serial transfer
// R6: start bit valid only at mid-period
// R7: busy assertion delayed in slow-clock mode
// R8: fifo depth sixteen sets full condition
// R9: writes ignored, reserved bits read zero
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps

module uart_fifo_status_flags (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [31:0]                addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [31:0]                rdata,
  input  wire uart_status_pkg::engine_type engine,
  output uart_status_pkg::status_type     status
);

  // fifo holds its full depth of entries
  function automatic logic level_full(input logic [4:0] lvl);
    level_full = (lvl >= uart_status_pkg::FIFO_DEPTH); // [R8]
  endfunction

  // fifo holds no entry at all
  function automatic logic level_empty(input logic [4:0] lvl);
    level_empty = (lvl == 5'h00);
  endfunction

  // register state
  logic [15:0]  div_reg;
  logic [15:0]  div_next;
  logic         clk_mode_reg;
  logic         clk_mode_next;
  logic [31:0]  rdata_reg;
  logic [31:0]  rdata_next;

  // baud tick and receive start detector state
  logic [15:0]  baud_cnt_reg;
  logic [15:0]  baud_cnt_next;
  logic         baud_tick;
  uart_status_pkg::rx_state_type rx_state_reg;
  uart_status_pkg::rx_state_type rx_state_next;
  logic [7:0]   rx_cnt_reg;
  logic [7:0]   rx_cnt_next;

  // slow clock emulation and busy synchroniser state
  logic [3:0]   slow_cnt_reg;
  logic [3:0]   slow_cnt_next;
  logic         slow_tick;
  logic [2:0]   sync_cnt_reg;
  logic [2:0]   sync_cnt_next;
  logic         busy_raw;

  // flag state
  uart_status_pkg::status_type status_reg;
  uart_status_pkg::status_type status_next;

  // register writes and registered read data; status is read-only
  always_comb begin
    div_next      = div_reg;
    clk_mode_next = clk_mode_reg;
    rdata_next    = 32'h0000_0000;
    if (wr_en) begin
      if (addr == uart_status_pkg::DIVISOR_ADDR) begin
        div_next = wdata[15:0];
      end
      if (addr == uart_status_pkg::CLK_MODE_ADDR) begin
        clk_mode_next = wdata[0];
      end
    end
    if (rd_en) begin
      unique case (addr)
        uart_status_pkg::STATUS_ADDR: begin
          rdata_next[uart_status_pkg::RFF_BIT]  =
            status_reg.rx_fifo_full_flag;
          rdata_next[uart_status_pkg::RFNE_BIT] =
            status_reg.rx_fifo_not_empty_flag;
          rdata_next[uart_status_pkg::TFE_BIT]  =
            status_reg.tx_fifo_empty_flag;
          rdata_next[uart_status_pkg::TFNF_BIT] =
            status_reg.tx_fifo_not_full_flag;
          rdata_next[uart_status_pkg::BUSY_BIT] =
            status_reg.busy_flag; // upper bits stay zero [R9]
        end
        uart_status_pkg::DIVISOR_ADDR: begin
          rdata_next[15:0] = div_reg;
        end
        uart_status_pkg::CLK_MODE_ADDR: begin
          rdata_next[0] = clk_mode_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000; // unmapped reads as zero
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_reg      <= uart_status_pkg::DIV_RESET;
      clk_mode_reg <= uart_status_pkg::CLK_MODE_RESET;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      div_reg      <= div_next;
      clk_mode_reg <= clk_mode_next;
      rdata_reg    <= rdata_next;
    end
  end

  // 16x oversample tick; a zero divisor behaves as one
  always_comb begin
    baud_tick     = (baud_cnt_reg + 16'h0001 >= div_reg);
    baud_cnt_next = baud_tick ? 16'h0000 : baud_cnt_reg + 16'h0001;
  end

  // start bit is only trusted once the line stays low to mid-bit,
  // so busy can read 0 during the first half of a start bit
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next   = rx_cnt_reg;
    unique case (rx_state_reg)
      uart_status_pkg::RX_IDLE: begin
        if (!engine.rx_line) begin
          rx_state_next = uart_status_pkg::RX_START_CHECK;
          rx_cnt_next   = 8'h00;
        end
      end
      uart_status_pkg::RX_START_CHECK: begin
        if (baud_tick) begin
          if (engine.rx_line) begin
            rx_state_next = uart_status_pkg::RX_IDLE; // glitch
          end else if (rx_cnt_reg + 8'h01 >=
                       uart_status_pkg::MID_TICKS) begin
            rx_state_next = uart_status_pkg::RX_FRAME; // [R6]
            rx_cnt_next   = 8'h00;
          end else begin
            rx_cnt_next = rx_cnt_reg + 8'h01;
          end
        end
      end
      uart_status_pkg::RX_FRAME: begin
        if (baud_tick) begin
          if (rx_cnt_reg + 8'h01 >= uart_status_pkg::FRAME_TICKS) begin
            rx_state_next = uart_status_pkg::RX_IDLE;
            rx_cnt_next   = 8'h00;
          end else begin
            rx_cnt_next = rx_cnt_reg + 8'h01;
          end
        end
      end
      // an illegal state code falls back to waiting for a start edge
      default: begin
        rx_state_next = uart_status_pkg::RX_IDLE;
        rx_cnt_next   = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      baud_cnt_reg <= 16'h0000;
      rx_state_reg <= uart_status_pkg::RX_IDLE;
      rx_cnt_reg   <= 8'h00;
    end else begin
      baud_cnt_reg <= baud_cnt_next;
      rx_state_reg <= rx_state_next;
      rx_cnt_reg   <= rx_cnt_next;
    end
  end

  // busy source: data held in either fifo, a shift out, or a
  // receive frame past its validated start bit
  always_comb begin
    busy_raw = engine.tx_shifting
             | (rx_state_reg == uart_status_pkg::RX_FRAME)
             | !level_empty(engine.tx_level)
             | !level_empty(engine.rx_level); // [R5] [R6]
  end

  // slow-clock emulation: assertion waits a few slow ticks,
  // release is immediate so software never sees a stale busy
  always_comb begin
    slow_tick     = (slow_cnt_reg + 4'h1 >= uart_status_pkg::SLOW_DIV);
    slow_cnt_next = slow_tick ? 4'h0 : slow_cnt_reg + 4'h1;
    sync_cnt_next = sync_cnt_reg;
    if (!busy_raw) begin
      sync_cnt_next = 3'h0;
    end else if (slow_tick &&
                 sync_cnt_reg < uart_status_pkg::SYNC_SLOW_CYCLES) begin
      sync_cnt_next = sync_cnt_reg + 3'h1; // [R7]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      slow_cnt_reg <= 4'h0;
      sync_cnt_reg <= 3'h0;
    end else begin
      slow_cnt_reg <= slow_cnt_next;
      sync_cnt_reg <= sync_cnt_next;
    end
  end

  // flags follow fifo levels one cycle later
  always_comb begin
    status_next.rx_fifo_full_flag      =
      level_full(engine.rx_level); // [R1] [R8]
    status_next.rx_fifo_not_empty_flag =
      !level_empty(engine.rx_level); // [R2]
    status_next.tx_fifo_empty_flag     =
      level_empty(engine.tx_level); // [R3]
    status_next.tx_fifo_not_full_flag  =
      !level_full(engine.tx_level); // [R4] [R8]
    if (clk_mode_reg) begin
      status_next.busy_flag = busy_raw &&
        (sync_cnt_reg >= uart_status_pkg::SYNC_SLOW_CYCLES); // [R7]
    end else begin
      status_next.busy_flag = busy_raw; // [R5]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status_reg.rx_fifo_full_flag      <= uart_status_pkg::RFF_RESET;
      status_reg.rx_fifo_not_empty_flag <= uart_status_pkg::RFNE_RESET;
      status_reg.tx_fifo_empty_flag     <= uart_status_pkg::TFE_RESET;
      status_reg.tx_fifo_not_full_flag  <= uart_status_pkg::TFNF_RESET;
      status_reg.busy_flag              <= uart_status_pkg::BUSY_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // outputs straight from flip-flops
  assign rdata  = rdata_reg;
  assign status = status_reg;

endmodule

// ===== verif/uart_remote_model.sv
// remote serial device that drives the receive line of the port
`timescale 1ns/1ps
module uart_remote_model (
  input  logic clk,
  output logic line
);
  // the line is pulled to mark level whenever nothing is sent
  initial line = 1'b1;

  // hold a level for a number of clocks; called right after an edge
  task automatic hold(input logic lvl, input int n);
    line <= lvl;
    repeat (n) @(posedge clk);
  endtask

  // one character: start bit, eight data bits lsb first, stop bit
  task automatic send(input logic [7:0] b, input int bit_clks);
    hold(1'b0, bit_clks);
    for (int i = 0; i < 8; i++) hold(b[i], bit_clks);
    hold(1'b1, bit_clks);
  endtask
endmodule

// ===== verif/uart_status_chk.sv
// concurrent checks on the ports of the status flag block
`timescale 1ns/1ps
module uart_status_chk (
  input logic                        clk,
  input logic                        srst,
  input logic [31:0]                 addr,
  input logic                        rd_en,
  input logic [31:0]                 rdata,
  input uart_status_pkg::engine_type engine,
  input uart_status_pkg::status_type status
);
  logic idle;

  // no engine activity, so only the receive line can make it busy
  assign idle = !engine.tx_shifting && engine.tx_level == 5'h00 &&
                engine.rx_level == 5'h00;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_rff;
    status.rx_fifo_full_flag == ($past(engine.rx_level) >= 5'h10);
  endproperty
  a_rff: assert property (p_rff) else $error("rx full flag wrong");

  property p_rfne;
    status.rx_fifo_not_empty_flag == ($past(engine.rx_level) != 5'h00);
  endproperty
  a_rfne: assert property (p_rfne) else $error("rx data flag wrong");

  property p_tfe;
    status.tx_fifo_empty_flag == ($past(engine.tx_level) == 5'h00);
  endproperty
  a_tfe: assert property (p_tfe) else $error("tx empty flag wrong");

  property p_tfnf;
    status.tx_fifo_not_full_flag == ($past(engine.tx_level) < 5'h10);
  endproperty
  a_tfnf: assert property (p_tfnf) else $error("tx room flag wrong");

  // slow mode may stretch the rise to thirteen cycles, never more
  property p_busy;
    $rose(engine.tx_shifting) |-> ##[1:14] status.busy_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("busy never rose");

  // a start edge is not trusted before mid-bit, even at divisor one
  property p_mid;
    $fell(engine.rx_line) && idle && !status.busy_flag |->
      !status.busy_flag [*7];
  endproperty
  a_mid: assert property (p_mid) else $error("busy before mid-bit");

  property p_rd0;
    !$past(rd_en) |-> rdata == 32'h0000_0000;
  endproperty
  a_rd0: assert property (p_rd0) else $error("read data not idle");

  property p_rdst;
    $past(rd_en) && $past(addr) == uart_status_pkg::STATUS_ADDR &&
      $stable(status) |-> rdata == {27'h0, status};
  endproperty
  a_rdst: assert property (p_rdst) else $error("status read wrong");
endmodule

bind uart_fifo_status_flags uart_status_chk chk_i (
  .clk(clk), .srst(srst), .addr(addr), .rd_en(rd_en), .rdata(rdata),
  .engine(engine), .status(status));

// ===== verif/uart_fifo_status_flags_bench.sv
// self-checking bench for the serial port status flags
`timescale 1ns/1ps
module uart_fifo_status_flags_bench;
  localparam logic [31:0] SA = uart_status_pkg::STATUS_ADDR;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [4:0]  txl = 5'h00;
  logic [4:0]  rxl = 5'h00;
  logic        sh = 1'b0;
  logic        line;
  int          err_count = 0;
  int          comparisons = 0;
  uart_status_pkg::status_type      st;
  wire uart_status_pkg::engine_type eng = {txl, rxl, sh, line};
  // tx level, rx level pairs around the empty and full boundaries
  logic [9:0] lv[6] = '{10'h001, 10'h020, 10'h1EF, 10'h210, 10'h200, 10'h000};

  uart_fifo_status_flags uut (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .engine(eng), .status(st));
  uart_remote_model far (.clk(clk), .line(line));

  always #25 clk = ~clk;

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
    // hand control back on an edge so callers drive at the edge
    @(posedge clk);
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] flags(input logic [9:0] l, input logic b);
    return {27'h0, l[4:0] >= 5'h10, l[4:0] != 5'h00, l[9:5] == 5'h00,
            l[9:5] < 5'h10, b};
  endfunction

  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // the tests need about eight hundred cycles
  initial begin
    #1000000;
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(SA);
    chk("reset flags", flags(10'h000, 1'b0), d);
    wr(SA, 32'hFFFF_FFFF);
    rd(SA);
    chk("after write", flags(10'h000, 1'b0), d);
    rd(32'h5000_1178);
    chk("unmapped", 32'h0, d);
    // held data counts as busy, so busy follows any nonzero level
    foreach (lv[i]) begin
      txl <= lv[i][9:5];
      rxl <= lv[i][4:0];
      @(posedge clk);
      rd(SA);
      chk("levels", flags(lv[i], |lv[i]), d);
    end
    wr(uart_status_pkg::DIVISOR_ADDR, 32'h0000_0004);
    rd(uart_status_pkg::DIVISOR_ADDR);
    chk("divisor", 32'h0000_0004, d);
    // a short low pulse must not start a frame
    far.hold(1'b0, 12);
    far.hold(1'b1, 8);
    #1 chk("glitch", 32'h0, {31'h0, st.busy_flag});
    @(posedge clk);
    fork
      far.send(8'hA5, 64);
      begin
        repeat (20) @(posedge clk);
        #1 chk("before mid", 32'h0, {31'h0, st.busy_flag});
        repeat (30) @(posedge clk);
        #1 chk("in frame", 32'h1, {31'h0, st.busy_flag});
      end
    join
    repeat (40) @(posedge clk);
    rd(SA);
    chk("after frame", flags(10'h000, 1'b0), d);
    wr(uart_status_pkg::CLK_MODE_ADDR, 32'h0000_0001);
    rd(uart_status_pkg::CLK_MODE_ADDR);
    chk("clock mode", 32'h0000_0001, d);
    sh <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("slow early", 32'h0, {31'h0, st.busy_flag});
    repeat (10) @(posedge clk);
    #1 chk("slow late", 32'h1, {31'h0, st.busy_flag});
    @(posedge clk);
    sh <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("slow idle", 32'h0, {31'h0, st.busy_flag});
    // a reset in mid-run must bring both own registers back to default
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(uart_status_pkg::DIVISOR_ADDR);
    chk("divisor reset", 32'h0000_0001, d);
    rd(uart_status_pkg::CLK_MODE_ADDR);
    chk("mode reset", 32'h0, d);
    rd(SA);
    chk("reset flags again", flags(10'h000, 1'b0), d);
    wr(uart_status_pkg::CLK_MODE_ADDR, 32'h0000_0000);
    sh <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("fast busy", 32'h1, {31'h0, st.busy_flag});
    sh <= 1'b0;
    print_verdict();
  end
endmodule
